// [testbench/msp_board.sv]
// board strapping and pin pull-up model for the port mux
`timescale 1ns/100ps
`default_nettype none
module msp_board (
	input wire logic rstn_i,
	input wire logic [1:0] sel_i,
	input wire logic mk_i,
	input wire logic mk_oe_i,
	input wire logic [63:0] pin_i,
	input wire logic [63:0] oe_i,
	output logic strap_a_o,
	output logic strap_b_o,
	output logic [63:0] lvl_o
);
	// second strap is tied high for the normal modes, low for the special ones
	assign strap_b_o = sel_i[1];
	// first strap: grounded, or pulled high and then shared with the open-drain marker
	assign strap_a_o = !rstn_i ? sel_i[0] : (sel_i[0] & !(mk_oe_i & !mk_i));
	// released pins float to the pull-up level
	assign lvl_o = (oe_i & pin_i) | ~oe_i;
endmodule : msp_board
`default_nettype wire

// [testbench/msp_mux_test.sv]
// self-checking bench for the port mux
`timescale 1ns/100ps
`default_nettype none
module msp_mux_test;
	logic mclk_i = 0, rstn_i = 0, fc = 0, dh = 0, sa, sb, bm, mk, mkoe;
	logic [1:0] q = 0, sel = 0, md;
	logic [63:0] gd = 0, go = 0, pe = 0, pd = 0, po = 0, lvl, pin, oe, pin_rd;
	logic [23:0] bd = 0, bo = 0;
	logic [7:0] lvb;
	logic [36:0] exq[$];
	int error_cnt = 0, comparisons = 0;
	initial forever #2 mclk_i = ~mclk_i;
	msp_board board (.rstn_i(rstn_i), .sel_i(sel), .mk_i(mk), .mk_oe_i(mkoe), .pin_i(pin), .oe_i(oe),
		.strap_a_o(sa), .strap_b_o(sb), .lvl_o(lvl));
	msp_mux dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_strap_a_i(sa), .mode_strap_b_i(sb),
		.fetch_first_cycle_i(fc), .fetch_marker_drive_high_i(dh), .osc_quarter_i(q), .gpio_dout_i(gd),
		.gpio_oe_i(go), .periph_en_i(pe), .periph_dout_i(pd), .periph_oe_i(po), .bus_dout_i(bd),
		.bus_oe_i(bo), .pin_i(lvl), .mode_o(md), .bus_mode_o(bm), .fetch_marker_out_o(mk),
		.fetch_marker_out_oe_o(mkoe), .pin_o(pin), .pin_oe_o(oe), .pin_in_o(pin_rd));
	task automatic check(input logic [36:0] seen, input logic [36:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD outputs exp %h seen %h", exp, seen);
		end
	endtask : check
	task automatic test_done();
		if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// expected {mode, bus mode, marker oe, marker high, port B oe, port E oe, port B out, port B level in}
	function automatic logic [36:0] ex(input logic [1:0] m, input logic ke, input logic k, input logic [7:0] lv);
		return {m, m[0], ke, k, m[0] ? bo[15:8] : go[15:8], 8'h00, m[0] ? bd[15:8] : gd[15:8], lv};
	endfunction : ex
	always @(negedge mclk_i)
		if (exq.size() > 0)
			check({md, bm, mkoe, mkoe & mk, oe[15:8], oe[39:32], pin[15:8], pin_rd[15:8]}, exq.pop_front());
	initial begin
		repeat (5000) @(posedge mclk_i);
		error_cnt++;
		test_done();
	end
	initial begin
		void'($urandom(28914));
		for (int m = 0; m < 4; m++) begin
			rstn_i = 1'b0;
			sel = m[1:0];
			repeat (3) @(posedge mclk_i);
			#1 rstn_i = 1'b1;
			go = {$urandom, $urandom};
			gd = {$urandom, $urandom};
			bo = 24'($urandom);
			bd = 24'($urandom);
			pe = {$urandom, $urandom};
			pd = {$urandom, $urandom};
			po = {$urandom, $urandom};
			// port B levels through the pull-ups once the new drive has passed the input flops
			lvb = m[0] ? ((bo[15:8] & bd[15:8]) | ~bo[15:8]) : ((go[15:8] & gd[15:8]) | ~go[15:8]);
			// straps flip after release; the latched mode must not follow
			sel = ~sel;
			fc = 1'b1;
			dh = m[1];
			exq.push_back(ex(m[1:0], m[0], 1'b0, 8'hFF));
			@(posedge mclk_i);
			#1 fc = 1'b0;
			exq.push_back(ex(m[1:0], m[0] & m[1], m[0] & m[1], 8'hFF));
			@(posedge mclk_i);
			#1 fc = 1'b1;
			q = 2'h1;
			exq.push_back(ex(m[1:0], m[0], 1'b0, lvb));
			@(posedge mclk_i);
			#1 fc = 1'b0;
			exq.push_back(ex(m[1:0], 1'b0, 1'b0, lvb));
			@(posedge mclk_i);
			#1 q = 2'h0;
		end
		repeat (2) @(posedge mclk_i);
		test_done();
	end
endmodule : msp_mux_test
`default_nettype wire

// [verilog/msp_defs.svh]
// constants for the mode select and port mux block
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH
`define MSP_PORT_W 8
`define MSP_PORTD_W 6
`define MSP_NPORT 8
`define MSP_PORT_A 3'h0
`define MSP_PORT_B 3'h1
`define MSP_PORT_C 3'h2
`define MSP_PORT_D 3'h3
`define MSP_PORT_E 3'h4
`define MSP_PORT_F 3'h5
`define MSP_PORT_G 3'h6
`define MSP_PORT_H 3'h7
`define MSP_PORTD_MASK 8'h3F
`define MSP_PORTG_REDUCED_MASK 8'h80
`define MSP_PORTH_REDUCED_MASK 8'h0F
`define MSP_PORTG_BUS_MASK 8'h80
`define MSP_PORTG_EXP_MASK 8'h3F
`define MSP_PORTH_EXP_MASK 8'hF0
`define MSP_QUARTERS 2'h3
`define MSP_RISE_QUARTER 2'h0
`endif

// [verilog/msp_mux.sv]
// mode strap capture, fetch marker pin and port function mux
// How it works
// - while reset is low the two straps choose one of four modes.
// - a low second strap selects the special modes, a high one the normal modes, and it is unused after reset.
// - in single-chip and bootstrap modes the first strap pin does nothing after reset.
// - in expanded and test modes the first strap pin becomes the open-drain active-low fetch marker.
// - the marker is pulled low for the first cycle of each instruction and released otherwise.
// - with the drive-high bit set the marker is driven high for one quarter cycle after release.
// - the full variant has 62 lines in ports A to H, all eight bits but port D with six.
// - the reduced variant drops port G bits 6 to 0 and port H bits 7 to 4, leaving 51 lines.
// - every port pin is two-way except port E, which never drives.
// - ports B, C, F and G bit 7 are plain I/O in single-chip and bootstrap, and the external bus otherwise.
// - other ports leave reset as plain I/O until software enables a peripheral function.
// - expansion address and chip selects on G and H can be enabled only in expanded modes.
// - the instruction clock runs at a quarter of the oscillator, low in processing and high in data access.
`timescale 1ns/100ps
`default_nettype none
`include "msp_defs.svh"
module msp_mux #(
	parameter bit REDUCED = 1'b0
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic mode_strap_a_i,
	input wire logic mode_strap_b_i,
	input wire logic fetch_first_cycle_i,
	input wire logic fetch_marker_drive_high_i,
	input wire logic [1:0] osc_quarter_i,
	input wire logic [`MSP_NPORT*8-1:0] gpio_dout_i,
	input wire logic [`MSP_NPORT*8-1:0] gpio_oe_i,
	input wire logic [`MSP_NPORT*8-1:0] periph_en_i,
	input wire logic [`MSP_NPORT*8-1:0] periph_dout_i,
	input wire logic [`MSP_NPORT*8-1:0] periph_oe_i,
	input wire logic [23:0] bus_dout_i,
	input wire logic [23:0] bus_oe_i,
	input wire logic [`MSP_NPORT*8-1:0] pin_i,
	output logic [1:0] mode_o,
	output logic bus_mode_o,
	output logic fetch_marker_out_o,
	output logic fetch_marker_out_oe_o,
	output logic [`MSP_NPORT*8-1:0] pin_o,
	output logic [`MSP_NPORT*8-1:0] pin_oe_o,
	output logic [`MSP_NPORT*8-1:0] pin_in_o
);
	logic [1:0] strap_meta_reg;
	logic [1:0] strap_sync_reg;
	logic [`MSP_NPORT*8-1:0] pin_meta_reg;
	logic [`MSP_NPORT*8-1:0] pin_sync_reg;
	msp_pkg::msp_mode_t mode_reg;
	logic bus_mode;
	logic expanded;
	logic first_prev_reg;
	msp_pkg::msp_drive_t drive [`MSP_NPORT];

	// ----------------------------------------
	// strap capture
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		strap_meta_reg <= {mode_strap_b_i, mode_strap_a_i};
		strap_sync_reg <= strap_meta_reg;
	end

	// mode follows the straps while reset is low and freezes at release
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			mode_reg <= msp_pkg::msp_mode_t'(strap_sync_reg);
		end
	end

	assign bus_mode = mode_reg[0]; // expanded or
	assign expanded = bus_mode;
	assign mode_o = mode_reg;
	assign bus_mode_o = bus_mode;

	// ----------------------------------------
	// fetch marker
	// ----------------------------------------
	// remembers an opcode fetch in the previous cycle, so the high drive only follows a release
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			first_prev_reg <= 1'b0;
		end else begin
			first_prev_reg <= fetch_first_cycle_i;
		end
	end

	always_comb begin
		fetch_marker_out_o = 1'b0;
		fetch_marker_out_oe_o = 1'b0;
		if (rstn_i && bus_mode) begin
			if (fetch_first_cycle_i) begin
				fetch_marker_out_oe_o = 1'b1;
			end else if (fetch_marker_drive_high_i && first_prev_reg
				&& osc_quarter_i == `MSP_RISE_QUARTER) begin
				fetch_marker_out_o = 1'b1;
				fetch_marker_out_oe_o = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// pin inputs
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		pin_meta_reg <= pin_i;
		pin_sync_reg <= pin_meta_reg;
	end
	assign pin_in_o = pin_sync_reg;

	// ----------------------------------------
	// port function mux
	// ----------------------------------------
	genvar p;
	generate
		for (p = 0; p < `MSP_NPORT; p++) begin : g_port
			logic [7:0] g_dout;
			logic [7:0] g_oe;
			logic [7:0] avail;
			logic [7:0] busm;
			logic [7:0] pen;
			always_comb begin
				avail = 8'hFF;
				busm = 8'h00;
				pen = periph_en_i[p*8 +: 8] & {8{rstn_i}};
				case (3'(p))
					`MSP_PORT_B, `MSP_PORT_C, `MSP_PORT_F: begin
						busm = {8{bus_mode}};
						pen = 8'h00; // bus ports have no peripheral function to hand over to
					end
					`MSP_PORT_D: avail = `MSP_PORTD_MASK;
					`MSP_PORT_E: avail = 8'h00;
					`MSP_PORT_G: begin
						busm = bus_mode ? `MSP_PORTG_BUS_MASK : 8'h00;
						pen = expanded ? (pen & `MSP_PORTG_EXP_MASK) : 8'h00;
						if (REDUCED) avail = `MSP_PORTG_REDUCED_MASK;
					end
					`MSP_PORT_H: begin
						if (!expanded) pen = pen & ~`MSP_PORTH_EXP_MASK;
						if (REDUCED) avail = `MSP_PORTH_REDUCED_MASK;
					end
					default: avail = 8'hFF;
				endcase
				busm = busm & {8{rstn_i}};
				g_dout = gpio_dout_i[p*8 +: 8];
				g_oe = gpio_oe_i[p*8 +: 8];
				for (int b = 0; b < 8; b++) begin
					if (busm[b]) begin
						g_dout[b] = (p == 6) ? bus_dout_i[23] : bus_dout_i[(p == 1 ? 8 : p == 2 ? 16 : 0) + b];
						g_oe[b] = (p == 6) ? bus_oe_i[23] : bus_oe_i[(p == 1 ? 8 : p == 2 ? 16 : 0) + b];
					end else if (pen[b]) begin
						g_dout[b] = periph_dout_i[p*8 + b];
						g_oe[b] = periph_oe_i[p*8 + b];
					end
				end
				g_oe = g_oe & avail & {8{rstn_i}};
			end
			assign drive[p] = '{dout: g_dout, oe: g_oe};
			assign pin_o[p*8 +: 8] = drive[p].dout;
			assign pin_oe_o[p*8 +: 8] = drive[p].oe;
		end
	endgenerate

	// ----------------------------------------
	// mode checks
	// ----------------------------------------
	a_mode_held: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rstn_i && $past(rstn_i) |-> mode_reg == $past(mode_reg))
		else $error("mode changed after reset");
	a_mode_capture: assert property (@(posedge mclk_i)
		$rose(rstn_i) |-> mode_reg == $past({mode_strap_b_i, mode_strap_a_i}, 3))
		else $error("mode not taken from straps");
	a_special_low: assert property (@(posedge mclk_i)
		$rose(rstn_i) |-> mode_reg[1] == $past(mode_strap_b_i, 3))
		else $error("special mode missed");

	// ----------------------------------------
	// fetch marker checks
	// ----------------------------------------
	a_marker_idle: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!bus_mode |-> !fetch_marker_out_oe_o)
		else $error("marker active in single-chip");
	a_marker_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		bus_mode && fetch_first_cycle_i |-> fetch_marker_out_oe_o && !fetch_marker_out_o)
		else $error("marker not low");
	a_marker_high: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		fetch_marker_out_o |-> fetch_marker_drive_high_i && !fetch_first_cycle_i)
		else $error("bad high drive");
	a_marker_rst: assert property (@(posedge mclk_i)
		!rstn_i |-> !fetch_marker_out_oe_o)
		else $error("marker driven in reset");
	a_marker_quarter: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		fetch_marker_out_o |-> osc_quarter_i == `MSP_RISE_QUARTER && $past(fetch_first_cycle_i))
		else $error("high drive outside its quarter");

	// ----------------------------------------
	// port checks
	// ----------------------------------------
	a_port_e_in: assert property (@(posedge mclk_i)
		pin_oe_o[39:32] == 8'h00)
		else $error("port E drives");
	a_port_d_w: assert property (@(posedge mclk_i)
		pin_oe_o[31:30] == 2'h0)
		else $error("port D upper bits drive");
	a_bus_b: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		bus_mode |-> pin_oe_o[15:8] == bus_oe_i[15:8])
		else $error("port B not bus");
	a_exp_g: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!bus_mode |-> pin_oe_o[53:48] == (gpio_oe_i[53:48] & {6{!REDUCED}}))
		else $error("port G expansion leak");
	a_oe_reset: assert property (@(posedge mclk_i)
		!rstn_i |-> pin_oe_o == 64'h0)
		else $error("pin driven in reset");
	a_bus_c_f: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		bus_mode |-> pin_oe_o[23:16] == bus_oe_i[23:16] && pin_oe_o[47:40] == bus_oe_i[7:0])
		else $error("ports C and F not bus");
	a_bus_g7: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		bus_mode |-> pin_oe_o[55] == bus_oe_i[23])
		else $error("port G bit 7 not bus");
	a_gpio_b: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!bus_mode |-> pin_oe_o[15:8] == gpio_oe_i[15:8] && pin_o[15:8] == gpio_dout_i[15:8])
		else $error("port B not plain io");
	a_exp_h: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!bus_mode |-> pin_oe_o[63:60] == (gpio_oe_i[63:60] & {4{!REDUCED}}))
		else $error("port H chip select leak");
	a_periph_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		periph_en_i[0] |-> pin_oe_o[0] == periph_oe_i[0] && pin_o[0] == periph_dout_i[0])
		else $error("port A peripheral not taken");
	a_exp_g_on: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		bus_mode && periph_en_i[48] |-> pin_oe_o[48] == (periph_oe_i[48] && !REDUCED))
		else $error("port G expansion not taken");
	a_pin_sync: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		pin_in_o == $past(pin_i, 2))
		else $error("pin input path broken");
endmodule : msp_mux
`default_nettype wire

// [verilog/msp_pkg.sv]
// types for the mode select and port mux block
`default_nettype none
package msp_pkg;
	typedef enum logic [1:0] {
		MSP_BOOTSTRAP = 2'h0,
		MSP_TEST = 2'h1,
		MSP_SINGLE = 2'h2,
		MSP_EXPANDED = 2'h3
	} msp_mode_t;
	// per-pin drive pair of a port
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
	} msp_drive_t;
endpackage : msp_pkg
`default_nettype wire
